/* logic/acq_ctrl_pkg.sv */
package acq_ctrl_pkg;
  localparam int MIN_DEPTH_LOG2      = 12;
  localparam int MAX_DEPTH_LOG2      = 21;
  localparam logic [21:0] MAX_TIMING_FULL  = 22'h0FE000;
  localparam logic [21:0] MAX_TIMING_HALF  = 22'h1FE000;
  localparam logic [21:0] MAX_STATE_PLAIN  = 22'h0FE000;
  localparam logic [21:0] MAX_STATE_ILV    = 22'h07E000;
  localparam logic [21:0] MAX_CMP_PLAIN    = 22'h03E000;
  localparam logic [21:0] MAX_CMP_ILV      = 22'h01E000;
  localparam logic [4:0]  DEPTH_LOG2_RST   = 5'h0C;
  localparam logic [3:0]  ARM_LEVEL_RST    = 4'h1;
  localparam logic [15:0] PERIOD_RST       = 16'h0001;

  typedef enum logic [1:0] {
    MODE_TIMING = 2'b00,
    MODE_STATE  = 2'b01,
    MODE_CMP    = 2'b10
  } acq_mode_t;

  typedef enum logic [1:0] {
    ARM_FREE  = 2'b00,
    ARM_PORT  = 2'b01,
    ARM_PEER  = 2'b10
  } arm_src_t;

  typedef enum logic [2:0] {
    POS_START  = 3'b000,
    POS_CENTER = 3'b001,
    POS_END    = 3'b010,
    POS_USER   = 3'b011,
    POS_DELAY  = 3'b100
  } trig_pos_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_WAIT  = 2'b01,
    ST_HUNT  = 2'b10,
    ST_DONE  = 2'b11
  } acq_state_t;
endpackage

/* logic/arm_trigger_acquire_ctrl.sv */
`timescale 1ns/1ps
module arm_trigger_acquire_ctrl
  import acq_ctrl_pkg::*;
#(
  parameter int DW      = 32,
  parameter int AW      = 21,
  parameter int PW      = 16,
  parameter int LVL_W   = 4,
  parameter int DELAY_W = 32
) (
  input  wire logic               ref_clk,
  input  wire logic               rstn,
  input  wire logic               ce,
  input  wire logic               run,
  input  wire logic               stop,
  input  wire acq_mode_t          acq_mode,
  input  wire arm_src_t           arm_src,
  input  wire logic               wait_arm,
  input  wire logic [LVL_W-1:0]   arm_level_sel,
  input  wire logic               arm_level_set,
  input  wire logic               ext_arm_pin,
  input  wire logic               peer_trig,
  input  wire logic               xtrig_from_self,
  input  wire logic               or_trig,
  input  wire logic               branch_store,
  input  wire logic               half_chan,
  input  wire logic               tags_on,
  input  wire logic               pod_pair_assigned,
  input  wire logic               pod_engine_enabled,
  input  wire logic [4:0]         depth_log2_req,
  input  wire logic               auto_mode,
  input  wire trig_pos_t          trig_pos,
  input  wire logic [AW-1:0]      user_pos,
  input  wire logic [DELAY_W-1:0] delay_ticks,
  input  wire logic [PW-1:0]      sample_period,
  input  wire logic               trig_match,
  input  wire logic               branch_taken,
  input  wire logic               in_valid,
  input  wire logic [DW-1:0]      in_data,
  output logic                    armed,
  output logic [LVL_W-1:0]        arm_level,
  output logic                    arm_level_load,
  output logic                    hunting,
  output logic                    triggered,
  output logic                    xtrig_out,
  output logic                    acq_done,
  output logic [4:0]              depth_log2,
  output logic                    depth_clamped,
  output logic                    tags_interleaved,
  output logic [AW-1:0]           trig_addr,
  output logic                    sample_tick,
  output logic                    out_valid,
  input  wire logic               out_ready,
  output logic [DW-1:0]           out_data,
  output logic                    out_branch,
  output logic                    stall
);
  // Three-stage pin synchroniser; stage one only feeds stage two
  logic [2:0] sync_q, sync_d;
  logic       arm_edge;

  always_comb begin
    sync_d = {sync_q[1:0], ext_arm_pin};
  end
  assign arm_edge = sync_q[1] && !sync_q[2];

  logic arm_evt;
  always_comb begin
    unique case (arm_src)
      ARM_FREE: arm_evt = 1'b1;
      ARM_PORT: arm_evt = arm_edge;
      ARM_PEER: arm_evt = peer_trig;
      default:  arm_evt = 1'b0;
    endcase
  end

  // Level register, defaults to level 1
  logic [LVL_W-1:0] lvl_q, lvl_d;
  always_comb begin
    lvl_d = lvl_q;
    if (arm_level_set) begin
      lvl_d = arm_level_sel;
    end
  end
  assign arm_level = lvl_q;

  // Memory depth selection
  logic            ilv;
  logic [21:0]     mode_max;
  logic [4:0]      dep_d, dep_q, req_c;
  assign ilv = tags_on && pod_pair_assigned && pod_engine_enabled;
  assign tags_interleaved = ilv;

  always_comb begin
    unique case (acq_mode)
      MODE_TIMING: mode_max = half_chan ? MAX_TIMING_HALF : MAX_TIMING_FULL;
      MODE_STATE:  mode_max = ilv ? MAX_STATE_ILV : MAX_STATE_PLAIN;
      MODE_CMP:    mode_max = ilv ? MAX_CMP_ILV : MAX_CMP_PLAIN;
      default:     mode_max = MAX_TIMING_FULL;
    endcase
  end

  // Largest power of two not above the mode maximum
  logic [4:0] max_log2;
  always_comb begin
    max_log2 = 5'(MIN_DEPTH_LOG2);
    for (int i = MIN_DEPTH_LOG2; i <= MAX_DEPTH_LOG2; i++) begin
      if ((22'h000001 << i) <= mode_max) begin
        max_log2 = 5'(i);
      end
    end
  end

  always_comb begin
    req_c = depth_log2_req;
    if (req_c < 5'(MIN_DEPTH_LOG2)) begin
      req_c = 5'(MIN_DEPTH_LOG2);
    end
    if (req_c > max_log2) begin
      req_c = max_log2;
    end
  end
  assign depth_clamped = (req_c != depth_log2_req);

  // Acquisition state machine
  acq_state_t       st_q, st_d;
  logic [PW-1:0]    per_q, per_d, pcnt_q, pcnt_d;
  logic [DELAY_W-1:0] dcnt_q, dcnt_d;
  logic             trg_q, trg_d, xo_q, xo_d, ld_q, ld_d;
  logic [AW-1:0]    wcnt_q, wcnt_d, post_q, post_d, tadr_q, tadr_d;
  logic [AW:0]      depth_n;
  logic             tick, delay_gate, push_ok, store_ok, buf_ready;
  logic [AW-1:0]    pos_c;

  assign depth_n = (AW+1)'(1) << dep_q;

  always_comb begin
    pos_c = '0;
    if (auto_mode) begin
      pos_c = AW'(depth_n >> 1);
    end else begin
      unique case (trig_pos)
        POS_START:  pos_c = '0;
        POS_CENTER: pos_c = AW'(depth_n >> 1);
        POS_END:    pos_c = AW'(depth_n - 1'b1);
        POS_USER:   pos_c = (user_pos < AW'(depth_n)) ? user_pos : AW'(depth_n - 1'b1);
        POS_DELAY:  pos_c = '0;
        default:    pos_c = AW'(depth_n >> 1);
      endcase
    end
  end

  // Timing samples only on the period tick; state mode takes every valid word except taken branches when branch_store is low
  assign tick = (acq_mode != MODE_TIMING) || (pcnt_q == '0);
  assign sample_tick = (st_q != ST_IDLE) && (acq_mode == MODE_TIMING) && (pcnt_q == '0);
  assign delay_gate = !auto_mode && trig_pos == POS_DELAY && acq_mode == MODE_TIMING
                      && dcnt_q != '0;
  assign store_ok = (acq_mode == MODE_TIMING) || !branch_taken || branch_store;
  assign push_ok = (st_q == ST_WAIT || st_q == ST_HUNT) && in_valid && tick
                   && !delay_gate && store_ok;
  assign stall = push_ok && !buf_ready;

  always_comb begin
    st_d   = st_q;
    per_d  = per_q;
    pcnt_d = pcnt_q;
    dcnt_d = dcnt_q;
    trg_d  = trg_q;
    xo_d   = 1'b0;
    ld_d   = 1'b0;
    wcnt_d = wcnt_q;
    post_d = post_q;
    tadr_d = tadr_q;
    dep_d  = dep_q;
    if (st_q != ST_IDLE && acq_mode == MODE_TIMING) begin
      pcnt_d = (pcnt_q == '0) ? per_q : pcnt_q - 1'b1;
    end
    if (st_q != ST_IDLE && delay_gate && tick) begin
      dcnt_d = dcnt_q - 1'b1;
    end
    if (push_ok && buf_ready) begin
      wcnt_d = wcnt_q + 1'b1;
      if (trg_q) begin
        post_d = post_q - 1'b1;
      end
    end
    case (st_q)
      ST_IDLE: begin
        if (run) begin
          dep_d  = req_c;
          per_d  = (sample_period == '0) ? PW'(PERIOD_RST) : sample_period;
          pcnt_d = '0;
          dcnt_d = delay_ticks;
          trg_d  = 1'b0;
          wcnt_d = '0;
          st_d   = wait_arm ? ST_WAIT : ST_HUNT;
        end
      end
      ST_WAIT: begin
        // Matches before arm are deliberately dropped
        if (arm_evt) begin
          ld_d = 1'b1;
          st_d = ST_HUNT;
        end
      end
      ST_HUNT: begin
        if (!trg_q && trig_match && in_valid && tick && !delay_gate) begin
          trg_d  = 1'b1;
          tadr_d = wcnt_q;
          post_d = AW'(depth_n - 1'b1) - pos_c;
          if (xtrig_from_self || or_trig) begin
            xo_d = 1'b1;
          end
        end
        if (!trg_q && or_trig && peer_trig) begin
          xo_d  = 1'b1;
          trg_d = trg_q;
        end
        if (trg_q && post_q == '0) begin
          st_d = ST_DONE;
        end
      end
      ST_DONE: begin
        st_d = ST_IDLE;
      end
      default: st_d = ST_IDLE;
    endcase
    if (stop) begin
      st_d = ST_IDLE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      sync_q <= 3'b000;
      lvl_q  <= LVL_W'(ARM_LEVEL_RST);
      st_q   <= ST_IDLE;
      dep_q  <= DEPTH_LOG2_RST;
      per_q  <= PW'(PERIOD_RST);
      pcnt_q <= '0;
      dcnt_q <= '0;
      trg_q  <= 1'b0;
      xo_q   <= 1'b0;
      ld_q   <= 1'b0;
      wcnt_q <= '0;
      post_q <= '0;
      tadr_q <= '0;
    end else if (ce) begin
      sync_q <= sync_d;
      lvl_q  <= lvl_d;
      st_q   <= st_d;
      dep_q  <= dep_d;
      per_q  <= per_d;
      pcnt_q <= pcnt_d;
      dcnt_q <= dcnt_d;
      trg_q  <= trg_d;
      xo_q   <= xo_d;
      ld_q   <= ld_d;
      wcnt_q <= wcnt_d;
      post_q <= post_d;
      tadr_q <= tadr_d;
    end
  end

  assign armed          = (st_q == ST_HUNT);
  assign hunting        = (st_q == ST_HUNT) && !trg_q;
  assign triggered      = trg_q;
  assign xtrig_out      = xo_q;
  assign arm_level_load = ld_q;
  assign acq_done       = (st_q == ST_DONE);
  assign depth_log2     = dep_q;
  assign trig_addr      = tadr_q;

  // Branch flag travels with the word; two entries absorb one stall
  logic [DW:0] buf_out;
  skid_buf #(.W(DW + 1)) u_buf (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .ce        (ce),
    .in_valid  (push_ok),
    .in_ready  (buf_ready),
    .in_data   ({branch_taken, in_data}),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (buf_out)
  );
  assign out_data   = buf_out[DW-1:0];
  assign out_branch = buf_out[DW];
endmodule

/* logic/skid_buf.sv */
`timescale 1ns/1ps
module skid_buf #(
  parameter int W = 32
) (
  input  wire logic         ref_clk,
  input  wire logic         rstn,
  input  wire logic         ce,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  logic [W-1:0] mem_q [2];
  logic [W-1:0] mem_d [2];
  logic         rd_q, rd_d, wr_q, wr_d;
  logic [1:0]   cnt_q, cnt_d;
  logic         push, pop;

  assign in_ready  = (cnt_q != 2'd2);
  assign out_valid = (cnt_q != 2'd0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    mem_d = mem_q;
    wr_d  = wr_q;
    rd_d  = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wr_q] = in_data;
      wr_d        = ~wr_q;
    end
    if (pop) begin
      rd_d = ~rd_q;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 2'd1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 2'd1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
      rd_q     <= 1'b0;
      wr_q     <= 1'b0;
      cnt_q    <= 2'd0;
    end else if (ce) begin
      mem_q <= mem_d;
      rd_q  <= rd_d;
      wr_q  <= wr_d;
      cnt_q <= cnt_d;
    end
  end
endmodule

/* tb/acq_ctrl_props.sv */
`timescale 1ns/1ps
module acq_ctrl_props
  import acq_ctrl_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       rstn,
  input wire logic       run,
  input wire logic       stop,
  input wire acq_mode_t  acq_mode,
  input wire logic       half_chan,
  input wire logic       tags_on,
  input wire logic       pod_pair_assigned,
  input wire logic       pod_engine_enabled,
  input wire logic [4:0] depth_log2_req,
  input wire logic       or_trig,
  input wire logic [3:0] arm_level,
  input wire logic       arm_level_load,
  input wire logic       armed,
  input wire logic       hunting,
  input wire logic       triggered,
  input wire logic       xtrig_out,
  input wire logic       acq_done,
  input wire logic [4:0] depth_log2,
  input wire logic       tags_interleaved
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  logic       ilv;
  logic [4:0] cap;
  logic [4:0] want;
  // Largest power of two that fits each mode's limit
  always_comb begin
    ilv = tags_on && pod_pair_assigned && pod_engine_enabled;
    case (acq_mode)
      MODE_TIMING: cap = half_chan ? 5'h14 : 5'h13;
      MODE_STATE:  cap = ilv ? 5'h12 : 5'h13;
      default:     cap = ilv ? 5'h10 : 5'h11;
    endcase
    want = (depth_log2_req < 5'h0C) ? 5'h0C : (depth_log2_req > cap) ? cap : depth_log2_req;
  end
  chk_reset_level: assert property ($rose(rstn) |-> arm_level == ARM_LEVEL_RST)
    else $error("arm level not default after reset");
  chk_depth_limit: assert property ($past(run) && !$past(stop) && !$past(armed)
    && !$past(hunting) |-> depth_log2 == $past(want)) else $error("depth not clamped");
  chk_tags_pod: assert property (tags_interleaved == ilv)
    else $error("tag interleave wrong");
  chk_hunt_armed: assert property (hunting |-> armed)
    else $error("hunting while not armed");
  chk_trig_hunt: assert property ($rose(triggered) |-> $past(hunting))
    else $error("trigger without hunt");
  chk_xtrig_own: assert property (xtrig_out && !$past(or_trig) |-> $rose(triggered))
    else $error("cross trigger before own trigger");
  chk_xtrig_pulse: assert property (xtrig_out |=> !xtrig_out)
    else $error("cross trigger longer than one cycle");
  chk_load_pulse: assert property (arm_level_load |=> !arm_level_load ##1 !arm_level_load)
    else $error("arm level load repeated");
  chk_done_pulse: assert property (acq_done |=> !acq_done && !hunting)
    else $error("done not a single pulse");
  cov_xtrig: cover property (xtrig_out);
  cov_load: cover property (arm_level_load);
  cov_done: cover property (acq_done);
endmodule

bind arm_trigger_acquire_ctrl acq_ctrl_props u_acq_ctrl_props (.ref_clk, .rstn, .run, .stop,
  .acq_mode, .half_chan, .tags_on, .pod_pair_assigned, .pod_engine_enabled, .depth_log2_req,
  .or_trig, .arm_level, .arm_level_load, .armed, .hunting, .triggered, .xtrig_out, .acq_done,
  .depth_log2, .tags_interleaved);

/* tb/arm_src_model.sv */
`timescale 1ns/1ps
module arm_src_model (
  input wire logic ref_clk,
  output logic     ext_arm_pin,
  output logic     peer_trig
);
  initial begin
    ext_arm_pin = 1'b0;
    peer_trig = 1'b0;
  end
  // Edge off the clock grid, so the synchroniser is really exercised
  task automatic arm_edge();
    @(posedge ref_clk);
    #7 ext_arm_pin = 1'b1;
    repeat (4) @(posedge ref_clk);
    #7 ext_arm_pin = 1'b0;
  endtask
  task automatic peer_pulse(input int n);
    @(posedge ref_clk);
    #1 peer_trig = 1'b1;
    repeat (n) @(posedge ref_clk);
    #1 peer_trig = 1'b0;
  endtask
endmodule

/* tb/arm_trigger_acquire_ctrl_tb.sv */
`timescale 1ns/1ps
module arm_trigger_acquire_ctrl_tb;
  import acq_ctrl_pkg::*;
  logic ref_clk, rstn, ce, run, stop, wait_arm, arm_level_set, ext_arm_pin, peer_trig;
  logic xtrig_from_self, or_trig, branch_store, half_chan, tags_on, pod_pair_assigned;
  logic pod_engine_enabled, auto_mode, trig_match, branch_taken, in_valid, out_ready;
  logic armed, arm_level_load, hunting, triggered, xtrig_out, acq_done, depth_clamped;
  logic tags_interleaved, sample_tick, out_valid, out_branch, stall;
  acq_mode_t   acq_mode;
  arm_src_t    arm_src;
  trig_pos_t   trig_pos;
  logic [3:0]  arm_level_sel, arm_level, ld_lvl;
  logic [4:0]  depth_log2_req, depth_log2;
  logic [20:0] user_pos, trig_addr;
  logic [31:0] delay_ticks, in_data, out_data;
  logic [15:0] sample_period;
  logic [14:0] cfg;
  int error_cnt, n_checks, cyc, xcnt, ldcnt, bcnt, dcnt, tcnt, x0, t0;
  // Mode, half, tags, pod assigned, requested and expected depth
  logic [14:0] tbl [9] = '{15'h6B3, 15'h16B4, 15'h26B3, 15'h2EB2, 15'h46B1, 15'h4EB0,
                           15'h4AB1, 15'h4AC, 15'h5AD};

  arm_trigger_acquire_ctrl u_arm_trigger_acquire_ctrl (.ref_clk, .rstn, .ce, .run, .stop,
    .acq_mode, .arm_src, .wait_arm, .arm_level_sel, .arm_level_set, .ext_arm_pin, .peer_trig,
    .xtrig_from_self, .or_trig, .branch_store, .half_chan, .tags_on, .pod_pair_assigned,
    .pod_engine_enabled, .depth_log2_req, .auto_mode, .trig_pos, .user_pos, .delay_ticks,
    .sample_period, .trig_match, .branch_taken, .in_valid, .in_data, .armed, .arm_level,
    .arm_level_load, .hunting, .triggered, .xtrig_out, .acq_done, .depth_log2, .depth_clamped,
    .tags_interleaved, .trig_addr, .sample_tick, .out_valid, .out_ready, .out_data, .out_branch,
    .stall);
  arm_src_model u_arm_src_model (.ref_clk, .ext_arm_pin, .peer_trig);

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic end_of_test();
    if (error_cnt == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic step(input int n = 1);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic start();
    run = 1'b1;
    step();
    run = 1'b0;
  endtask
  task automatic halt();
    stop = 1'b1;
    step();
    stop = 1'b0;
    step(2);
  endtask
  // Held a full tick period so a slow sample clock cannot miss it
  task automatic fire();
    trig_match = 1'b1;
    in_valid = 1'b1;
    step(4);
    trig_match = 1'b0;
    step(2);
  endtask

  always @(posedge ref_clk) begin
    if (xtrig_out === 1'b1) xcnt++;
    if (arm_level_load === 1'b1) begin
      ldcnt++;
      ld_lvl = arm_level;
    end
    if (out_valid === 1'b1 && out_ready && out_branch === 1'b1) bcnt++;
    if (acq_done === 1'b1) dcnt++;
    if (sample_tick === 1'b1) tcnt++;
    if (++cyc > 60000) begin
      error_cnt++;
      end_of_test();
    end
  end

  initial begin
    {rstn, run, stop, wait_arm, arm_level_set, or_trig, half_chan, tags_on} = '0;
    {trig_match, branch_taken, in_valid, user_pos, delay_ticks, in_data} = '0;
    {ce, xtrig_from_self, branch_store, pod_pair_assigned, pod_engine_enabled} = '1;
    {auto_mode, out_ready} = 2'b11;
    acq_mode = MODE_TIMING;
    arm_src = ARM_FREE;
    trig_pos = POS_CENTER;
    arm_level_sel = 4'h0;
    depth_log2_req = 5'h0C;
    sample_period = 16'h0003;
    step(4);
    rstn = 1'b1;
    step();
    chk(arm_level, 4'h1);
    chk(depth_log2, 5'h0C);
    foreach (tbl[i]) begin
      cfg = tbl[i];
      acq_mode = acq_mode_t'(cfg[14:13]);
      {half_chan, tags_on, pod_pair_assigned, depth_log2_req} = cfg[12:5];
      start();
      chk(depth_log2, cfg[4:0]);
      chk(depth_clamped, cfg[9:5] != cfg[4:0]);
      chk(tags_interleaved, cfg[11] & cfg[10]);
      chk(armed, 1'b1);
      halt();
    end
    {tags_on, pod_pair_assigned, pod_engine_enabled} = 3'b110;
    step();
    chk(tags_interleaved, 1'b0);
    {tags_on, pod_engine_enabled} = 2'b01;
    {acq_mode, depth_log2_req, pod_pair_assigned} = {MODE_TIMING, 5'h0C, 1'b1};
    arm_src = ARM_PORT;
    wait_arm = 1'b1;
    arm_level_sel = 4'h5;
    arm_level_set = 1'b1;
    step();
    arm_level_set = 1'b0;
    start();
    fire();
    chk(triggered, 1'b0);
    u_arm_src_model.arm_edge();
    step(2);
    chk(ldcnt, 1);
    chk(ld_lvl, 4'h5);
    t0 = tcnt;
    step(40);
    chk(tcnt - t0, 10);
    x0 = xcnt;
    fire();
    chk(triggered, 1'b1);
    chk(xcnt - x0, 1);
    for (int k = 0; k < 20000 && dcnt == 0; k++) step();
    chk(dcnt, 1);
    in_valid = 1'b0;
    step(3);
    arm_src = ARM_PEER;
    start();
    step(3);
    chk(armed, 1'b0);
    x0 = xcnt;
    u_arm_src_model.peer_pulse(3);
    step();
    chk(hunting, 1'b1);
    chk(xcnt - x0, 0);
    fire();
    chk(xcnt - x0, 1);
    chk(trig_addr, 21'h000000);
    halt();
    {arm_src, wait_arm, or_trig, xtrig_from_self} = {ARM_FREE, 3'b010};
    start();
    x0 = xcnt;
    u_arm_src_model.peer_pulse(1);
    step(2);
    chk(xcnt - x0, 1);
    halt();
    {acq_mode, or_trig} = {MODE_STATE, 1'b0};
    for (int b = 0; b < 2; b++) begin
      branch_store = b[0];
      out_ready = 1'b0;
      in_data = 32'h000000A5;
      start();
      {branch_taken, in_valid} = 2'b11;
      step(6);
      chk(stall, b[0]);
      if (b == 1) chk(out_data, 32'h000000A5);
      x0 = bcnt;
      out_ready = 1'b1;
      step(6);
      chk(bcnt > x0, b[0]);
      {branch_taken, in_valid} = 2'b00;
      halt();
    end
    end_of_test();
  end
endmodule
